// *** bench/i2c_master_model.sv ***
// Two-wire bus master model: makes the clock and pulls the data line low.
// Assumes the bench resolves the data wire with its pull-up and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   // Clock
   input wire logic core_clk,
   // Bus
   input wire logic sda_wire,
   output logic scl,
   output logic sda_low
);
   // Five core clocks per phase keeps each bus change well clear of the slave's one-clock edge sampling
   localparam int GAP = 5;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   task automatic pause();
      repeat (GAP) @(posedge core_clk);
   endtask
   task automatic start();
      sda_low <= 1'b0;
      pause();
      scl <= 1'b1;
      pause();
      sda_low <= 1'b1;
      pause();
      scl <= 1'b0;
      pause();
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      pause();
      scl <= 1'b1;
      pause();
      sda_low <= 1'b0;
      pause();
   endtask
   task automatic clk_bit(input logic b, output logic s);
      sda_low <= !b;
      pause();
      scl <= 1'b1;
      pause();
      s = sda_wire;
      scl <= 1'b0;
      pause();
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic nak, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
      clk_bit(nak, s);
      ack = !s;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d[$], output logic ok);
      logic [7:0] r;
      logic a;
      start();
      byte_io({dev, 1'b0}, 1'b1, r, ok);
      byte_io(ofs, 1'b1, r, a);
      ok = ok & a;
      foreach (d[i]) begin
         byte_io(d[i], 1'b1, r, a);
         ok = ok & a;
      end
      stop();
   endtask
   // Reads cnt bytes, acknowledging all but the last; with two, the first lands in the upper half
   task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input int cnt, output logic [15:0] v,
      output logic ok);
      logic [7:0] r;
      logic a;
      logic b;
      logic x;
      v = 16'h0000;
      start();
      byte_io({dev, 1'b0}, 1'b1, r, a);
      byte_io(ofs, 1'b1, r, b);
      start();
      byte_io({dev, 1'b1}, 1'b1, r, ok);
      for (int i = cnt; i > 0; i--) begin
         byte_io(8'hff, i == 1, r, x);
         v = {v[7:0], r};
      end
      ok = ok & a & b;
      stop();
   endtask
endmodule // i2c_master_model
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the port block, reached through the bus master model.
// Assumes the package, design files, checker and master model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import touch_ctrl_gpio_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic run_mode = 1'b0;
   logic conv_busy = 1'b0;
   logic [7:0] sense_sel = 8'h00;
   logic [7:0] pad_in = 8'h00;
   logic [1:0] strap = 2'h0;
   logic [6:0] dev = SLAVE_ADDR_GND;
   logic sda_out, sda_oe, soft_restart_pulse;
   logic [7:0] pad_out, pad_oe, pull_up_en, pull_dn_en;
   wire logic scl, sda_low, sda_wire, addr_pin;
   logic [31:0] pads_now;
   int error_cnt = 0;
   int comparisons = 0;
   int pulses = 0;
   always #4 core_clk = ~core_clk;
   assign sda_wire = !(sda_low || (sda_oe && !sda_out));
   assign addr_pin = (strap == 2'h0) ? 1'b0 : (strap == 2'h1) ? 1'b1 : (strap == 2'h2) ? sda_wire : scl;
   assign pads_now = {pad_out & pad_oe, pad_oe, pull_up_en, pull_dn_en};
   always @(posedge core_clk) if (soft_restart_pulse === 1'b1) pulses <= pulses + 1;
   touch_ctrl_gpio_port dut (.core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin_in(addr_pin), .run_mode(run_mode), .sense_sel(sense_sel),
      .conv_busy(conv_busy), .soft_restart_pulse(soft_restart_pulse), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));
   i2c_master_model m (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d[$]);
      logic ok;
      m.wr(dev, ofs, d, ok);
      check(ok, 1'b1);
   endtask
   task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
      logic [15:0] v;
      logic ok;
      m.rd(dev, ofs, 1, v, ok);
      check(ok, 1'b1);
      check(v, exp);
   endtask
   // Config word is {mode a, mode b, level, direction, enable}, written from 0x73 upward
   task automatic cfgw(input logic [39:0] c);
      wr(OFS_DRIVE_MODE_A, '{c[39:32], c[31:24], c[23:16], c[15:8], c[7:0]});
      repeat (4) @(posedge core_clk);
   endtask
   function automatic logic [31:0] pads_exp(input logic [39:0] c, input logic [7:0] blk);
      logic [7:0] oe, out, pu, pd, e;
      {oe, out, pu, pd} = '0;
      e = c[7:0] & ~blk;
      for (int i = 0; i < 8; i++) begin
         if (!e[i]) continue;
         if (!c[8+i]) {pu[i], pd[i]} = {c[32+i] & c[24+i], c[32+i] & !c[24+i]};
         else if (c[32+i]) {out[i], oe[i]} = {c[24+i], c[24+i] ~^ c[16+i]};
         else {out[i], oe[i]} = {c[16+i], 1'b1};
      end
      return {out & oe, oe, pu, pd};
   endfunction
   ////////////////////////////////////////////////////////////
   task automatic t_reset_vals();
      for (int o = 8'h73; o <= 8'h7a; o++) rd_chk(8'(o), PORT_RESET);
      rd_chk(OFS_SOFT_RESTART, UNMAPPED_READ);
      wr(8'h40, '{8'hff});
      rd_chk(8'h40, UNMAPPED_READ);
      check(pads_now, 32'h0);
   endtask
   task automatic t_modes();
      logic [39:0] c[2] = '{{8'hcc, 8'haa, 8'h55, 8'h0f, 8'hff}, {8'hcc, 8'haa, 8'haa, 8'h0f, 8'h7e}};
      foreach (c[k]) begin
         cfgw(c[k]);
         check(pads_now, pads_exp(c[k], 8'h00));
      end
      run_mode <= 1'b1;
      sense_sel <= 8'h3c;
      repeat (4) @(posedge core_clk);
      check(pads_now, pads_exp(c[1], 8'h3c));
      run_mode <= 1'b0;
      repeat (4) @(posedge core_clk);
      check(pads_now, pads_exp(c[1], 8'h00));
      sense_sel <= 8'h00;
   endtask
   task automatic t_level();
      logic [15:0] v2;
      logic ok;
      cfgw({8'h00, 8'h00, 8'h00, 8'hff, 8'hff});
      run_mode <= 1'b1;
      wr(OFS_LEVEL_RAISE, '{8'ha5, 8'h21, 8'h0f});
      run_mode <= 1'b0;
      rd_chk(OFS_PORT_LEVEL, 8'h8b);
      for (int o = 8'h78; o <= 8'h7a; o++) rd_chk(8'(o), 8'h8b);
      // Two-byte read walks the pointer from the enable register into the set register
      m.rd(dev, OFS_PORT_ACTIVE, 2, v2, ok);
      check(ok, 1'b1);
      check(v2, 16'hff8b);
      check(pad_out, 8'h8b);
      conv_busy <= 1'b1;
      wr(OFS_PORT_LEVEL, '{8'h3c});
      repeat (8) @(posedge core_clk);
      check(pad_out, 8'h8b);
      conv_busy <= 1'b0;
      repeat (4) @(posedge core_clk);
      check(pad_out, 8'h3c);
   endtask
   task automatic t_inputs();
      pad_in <= 8'h5a;
      cfgw({8'h00, 8'h00, 8'hc3, 8'h00, 8'hf0});
      rd_chk(OFS_PORT_LEVEL, 8'h53);
      wr(OFS_PORT_LEVEL, '{8'h0f});
      rd_chk(OFS_LEVEL_INVERT, 8'h5f);
      check(pads_now, 32'h0);
   endtask
   task automatic t_soft();
      wr(OFS_SOFT_RESTART, '{8'h55});
      rd_chk(OFS_PORT_ACTIVE, 8'hf0);
      wr(OFS_SOFT_RESTART, '{SOFT_RESTART_KEY});
      check(pulses, 1);
      t_reset_vals();
   endtask
   task automatic t_strap();
      logic [6:0] tbl[4] = '{SLAVE_ADDR_GND, SLAVE_ADDR_SUPPLY, SLAVE_ADDR_DATA, SLAVE_ADDR_CLOCK};
      logic ok;
      for (int s = 0; s < 4; s++) begin
         strap <= 2'(s);
         do_reset();
         dev = tbl[s];
         m.wr(dev ^ 7'h01, OFS_PORT_ACTIVE, '{8'h11}, ok);
         check(ok, 1'b0);
         wr(OFS_PORT_ACTIVE, '{8'(s + 1)});
         rd_chk(OFS_PORT_ACTIVE, 8'(s + 1));
      end
   endtask
   initial begin
      do_reset();
      t_reset_vals();
      t_modes();
      t_level();
      t_inputs();
      t_soft();
      t_strap();
      results();
   end
   // Each transfer is a fixed number of cycles, so only a stuck run reaches this
   initial begin
      repeat (90000) @(posedge core_clk);
      error_cnt++;
      results();
   end
endmodule // tb
bind touch_ctrl_gpio_port touch_ctrl_gpio_port_checker chk (.core_clk(core_clk), .srst(srst), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .run_mode(run_mode), .sense_sel(sense_sel), .conv_busy(conv_busy),
   .soft_restart_pulse(soft_restart_pulse), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
   .pull_dn_en(pull_dn_en));
`default_nettype wire

// *** bench/touch_ctrl_gpio_port_checker.sv ***
// Concurrent checks on the pad and bus outputs of the port block.
// Assumes it is bound to touch_ctrl_gpio_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module touch_ctrl_gpio_port_checker
   import touch_ctrl_gpio_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Bus
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Sensing core
   input wire logic run_mode,
   input wire logic [PORT_W-1:0] sense_sel,
   input wire logic conv_busy,
   input wire logic soft_restart_pulse,
   // Pads
   input wire logic [PORT_W-1:0] pad_out,
   input wire logic [PORT_W-1:0] pad_oe,
   input wire logic [PORT_W-1:0] pull_up_en,
   input wire logic [PORT_W-1:0] pull_dn_en
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [PORT_W-1:0] used_pins;
   assign used_pins = pad_oe | pull_up_en | pull_dn_en;
   ////////////////////////////////////////////////////////////
   chk_pull_excl: assert property ((pull_up_en & pull_dn_en) == '0)
      else $error("pull-up and pull-down on together");
   chk_drive_no_pull: assert property ((pad_oe & (pull_up_en | pull_dn_en)) == '0)
      else $error("driven pin also has a pull");
   chk_reset_clear: assert property ($past(srst) |-> used_pins == '0 && !sda_oe)
      else $error("pins not quiet after reset");
   // Three cycles of a steady selection covers the registered pad path
   chk_sense_drop: assert property ((run_mode && $stable(sense_sel)) [*3] |-> (used_pins & sense_sel) == '0)
      else $error("sensing pin still used as port");
   chk_busy_hold: assert property (conv_busy && $past(conv_busy) && $stable(pad_oe) |-> $stable(pad_out))
      else $error("output level moved during conversion");
   chk_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data pulled while clock high");
   chk_sda_quiet: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data changed while clock high");
   chk_sda_drain: assert property (sda_out == 1'b0)
      else $error("data line driven high");
   chk_pulse_single: assert property (soft_restart_pulse |=> !soft_restart_pulse)
      else $error("restart pulse longer than one cycle");
   chk_soft_clear: assert property (soft_restart_pulse |-> ##[0:2] used_pins == '0)
      else $error("pins not cleared by soft restart");
   cover property (soft_restart_pulse);
   cover property ($rose(sda_oe));
   cover property (conv_busy && pad_oe != '0);
endmodule // touch_ctrl_gpio_port_checker
`default_nettype wire

// *** logic/gpio_pin_cell.sv ***
// One multifunction pin: decodes enable, direction and drive mode into pad controls.
// Purely combinational; the parent registers every result.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell
   import touch_ctrl_gpio_pkg::*;
(
   // Configuration
   input wire logic port_on,
   input wire logic dir_out,
   input wire logic mode_a,
   input wire logic mode_b,
   input wire logic level,
   // Pad controls
   output logic drive,
   output logic drive_oe,
   output logic pull_up,
   output logic pull_dn
);
   always_comb begin
      drive = 1'b0;
      drive_oe = 1'b0;
      pull_up = 1'b0;
      pull_dn = 1'b0;
      if (port_on) begin // RQ6
         if (dir_out) begin
            unique case ({mode_a, mode_b}) // RQ8
               MODE_HIGH_SIDE: begin
                  drive = 1'b1;
                  drive_oe = level; // RQ9
               end
               MODE_LOW_SIDE: begin
                  drive = 1'b0;
                  drive_oe = ~level;
               end
               default: begin
                  // 00 and the undefined 01 both give push-pull
                  drive = level;
                  drive_oe = 1'b1;
               end
            endcase
         end else begin
            pull_dn = ({mode_a, mode_b} == MODE_PULL_DN); // RQ7
            pull_up = ({mode_a, mode_b} == MODE_PULL_UP); // RQ7
         end
      end
   end
endmodule // gpio_pin_cell
`default_nettype wire

// *** logic/i2c_reg_slave.sv ***
// Two-wire slave with register addressing and address auto-increment.
// Assumes scl/sda/strap inputs already synchronous to core_clk; only srst resets it.
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_slave
   import touch_ctrl_gpio_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_pin_in,
   // Register side
   output logic wr_stb,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_MACK} bus_state_t;

   typedef struct packed {
      logic scl, sda;
      bus_state_t st;
      logic [2:0] cnt;
      logic [7:0] sh, reg_ptr, wa, wd;
      logic full, first, tx_next, acked, oe, stb;
      logic seen0, seen1, diff_sda;
   } slave_state_t;

   slave_state_t q, n;
   logic start_c, stop_c, rise, fall;
   logic [6:0] my_addr;

   assign start_c = scl_in & q.scl & q.sda & ~sda_in;
   assign stop_c = scl_in & q.scl & ~q.sda & sda_in;
   assign rise = scl_in & ~q.scl;
   assign fall = ~scl_in & q.scl;

   // Strap follows ground, supply, data or clock line
   always_comb begin
      if (!q.seen1) my_addr = SLAVE_ADDR_GND; // RQ17
      else if (!q.seen0) my_addr = SLAVE_ADDR_SUPPLY;
      else if (!q.diff_sda) my_addr = SLAVE_ADDR_DATA;
      else my_addr = SLAVE_ADDR_CLOCK;
   end

   always_comb begin
      n = q;
      n.scl = scl_in;
      n.sda = sda_in;
      n.stb = 1'b0;
      n.seen0 = q.seen0 | ~addr_pin_in;
      n.seen1 = q.seen1 | addr_pin_in;
      n.diff_sda = q.diff_sda | (addr_pin_in ^ sda_in);
      if (start_c) begin // RQ16
         n.st = S_ADDR;
         n.cnt = 3'h0;
         n.full = 1'b0;
         n.oe = 1'b0;
      end else if (stop_c) begin
         n.st = S_IDLE;
         n.oe = 1'b0;
      end else begin
         unique case (q.st)
            S_IDLE: ;
            S_ADDR, S_RX: begin
               if (rise) begin
                  n.sh = {q.sh[6:0], sda_in};
                  n.cnt = q.cnt + 3'h1;
                  n.full = (q.cnt == 3'h7);
               end else if (fall && q.full) begin
                  n.full = 1'b0;
                  n.oe = 1'b1;
                  n.st = S_ACK;
                  n.tx_next = 1'b0;
                  if (q.st == S_ADDR) begin
                     if (q.sh[7:1] == my_addr) begin
                        n.tx_next = q.sh[0];
                        n.first = ~q.sh[0];
                     end else begin
                        n.oe = 1'b0;
                        n.st = S_IDLE;
                     end
                  end else if (q.first) begin
                     n.reg_ptr = q.sh;
                     n.first = 1'b0;
                  end else begin
                     n.stb = 1'b1;
                     n.wa = q.reg_ptr;
                     n.wd = q.sh;
                     n.reg_ptr = q.reg_ptr + 8'h01;
                  end
               end
            end
            S_ACK: begin
               if (fall) begin
                  n.cnt = 3'h0;
                  n.oe = 1'b0;
                  n.st = S_RX;
                  if (q.tx_next) begin
                     n.sh = rd_data;
                     n.oe = ~rd_data[7]; // RQ15
                     n.st = S_TX;
                  end
               end
            end
            S_TX: begin
               if (fall) begin
                  n.cnt = q.cnt + 3'h1;
                  n.sh = {q.sh[6:0], 1'b0};
                  n.oe = ~q.sh[6];
                  if (q.cnt == 3'h7) begin
                     n.oe = 1'b0;
                     n.st = S_MACK;
                     n.reg_ptr = q.reg_ptr + 8'h01;
                  end
               end
            end
            S_MACK: begin
               if (rise) n.acked = ~sda_in;
               else if (fall) begin
                  n.cnt = 3'h0;
                  n.st = S_IDLE;
                  if (q.acked) begin
                     n.sh = rd_data;
                     n.oe = ~rd_data[7];
                     n.st = S_TX;
                  end
               end
            end
            default: n.st = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q <= '0;
         q.scl <= 1'b1;
         q.sda <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = q.oe;
   assign wr_stb = q.stb;
   assign wr_addr = q.wa;
   assign wr_data = q.wd;
   assign rd_addr = q.reg_ptr;
endmodule // i2c_reg_slave
`default_nettype wire

// *** logic/touch_ctrl_gpio_pkg.sv ***
// Shared constants for the multifunction port block and its serial slave.
// Assumes an 8-bit register address space reached over the two-wire slave.
package touch_ctrl_gpio_pkg;

   localparam int PORT_W = 8;

   // Register offsets
   localparam logic [7:0] OFS_DRIVE_MODE_A = 8'h73;
   localparam logic [7:0] OFS_DRIVE_MODE_B = 8'h74;
   localparam logic [7:0] OFS_PORT_LEVEL = 8'h75;
   localparam logic [7:0] OFS_OUTPUT_SELECT = 8'h76;
   localparam logic [7:0] OFS_PORT_ACTIVE = 8'h77;
   localparam logic [7:0] OFS_LEVEL_RAISE = 8'h78;
   localparam logic [7:0] OFS_LEVEL_LOWER = 8'h79;
   localparam logic [7:0] OFS_LEVEL_INVERT = 8'h7a;
   localparam logic [7:0] OFS_SOFT_RESTART = 8'h80;

   localparam logic [7:0] SOFT_RESTART_KEY = 8'h63;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Drive-mode pair {mode_a, mode_b}
   localparam logic [1:0] MODE_PULL_DN = 2'b10;
   localparam logic [1:0] MODE_PULL_UP = 2'b11;
   localparam logic [1:0] MODE_HIGH_SIDE = 2'b11;
   localparam logic [1:0] MODE_LOW_SIDE = 2'b10;

   // Slave address by strap connection
   localparam logic [6:0] SLAVE_ADDR_GND = 7'h5a;
   localparam logic [6:0] SLAVE_ADDR_SUPPLY = 7'h5b;
   localparam logic [6:0] SLAVE_ADDR_DATA = 7'h5c;
   localparam logic [6:0] SLAVE_ADDR_CLOCK = 7'h5d;

endpackage

// *** logic/touch_ctrl_gpio_port.sv ***
// Multifunction port block for the eight pins shared with sensing inputs 4 to 11.
// Assumes the sensing core supplies run mode, electrode selection and conversion busy.
//
// How it works
// [RQ1] Writing 0x63 to 0x80 resets everything like power-on, except the serial slave.
// [RQ2] Bits 7..0 of each port register control pins of sensing inputs 11..4.
// [RQ3] Port registers accept writes at any time, stopped or running.
// [RQ4] A pin selected for sensing in run mode loses its port function immediately.
// [RQ5] After power-on all ports are disabled, so every pin floats.
// [RQ6] A disabled port holds its pin high impedance whatever else is set.
// [RQ7] Input modes: 00 plain, 10 pull-down, 11 pull-up, 01 same as 00.
// [RQ8] Output modes: 00 push-pull, 11 high-side only, 10 low-side only, 01 as 00.
// [RQ9] An enabled output drives the level held in the port level register.
// [RQ10] Output level changes wait until the running conversion completes.
// [RQ11] Level reads give stored bits for outputs and latched pin levels for inputs.
// [RQ12] Writing the level register does not disturb input sampling or reporting.
// [RQ13] Ones written to 0x78, 0x79, 0x7a set, clear or toggle level bits.
// [RQ14] Reading the set, clear and toggle registers returns the level read value.
// [RQ15] Slave only: clock is input, data is input plus open-drain output.
// [RQ16] Transfer is start, address with direction, register byte, data bytes, stop.
// [RQ17] Slave address 0x5a to 0x5d follows strap tied to ground, supply, data, clock.
// [RQ18] Multi-master hosts should avoid repeated starts and rewrite the register address.
// [RQ19] All port registers are eight bits and clear to zero on any reset.
`timescale 1ns/1ps
`default_nettype none
module touch_ctrl_gpio_port
   import touch_ctrl_gpio_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_pin_in,
   // Sensing core
   input wire logic run_mode,
   input wire logic [PORT_W-1:0] sense_sel,
   input wire logic conv_busy,
   output logic soft_restart_pulse,
   // Pads
   input wire logic [PORT_W-1:0] pad_in,
   output logic [PORT_W-1:0] pad_out,
   output logic [PORT_W-1:0] pad_oe,
   output logic [PORT_W-1:0] pull_up_en,
   output logic [PORT_W-1:0] pull_dn_en
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [PORT_W-1:0] mode_a, mode_b, level, out_sel, active;
      logic [PORT_W-1:0] drive_lvl, in_lat;
      logic [PORT_W-1:0] p_out, p_oe, p_up, p_dn;
      logic soft_restart;
   } port_state_t;

   port_state_t q, n;
   logic wr_stb;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
   logic [PORT_W-1:0] port_on, is_in, level_rd;
   logic [PORT_W-1:0] c_out, c_oe, c_up, c_dn;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial slave, kept out of the soft restart so the acknowledging transfer ends cleanly

   i2c_reg_slave u_slave (
      .core_clk(core_clk),
      .srst(srst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .addr_pin_in(addr_pin_in),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   ); // RQ15 RQ16 RQ17

   ////////////////////////////////////////////////////////////////////////////////
   // Pins

   assign port_on = q.active & ~({PORT_W{run_mode}} & sense_sel); // RQ4
   assign is_in = q.active & ~q.out_sel;

   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi++) begin : g_pin // RQ2
         gpio_pin_cell u_cell (
            .port_on(port_on[gi]),
            .dir_out(q.out_sel[gi]),
            .mode_a(q.mode_a[gi]),
            .mode_b(q.mode_b[gi]),
            .level(q.drive_lvl[gi]),
            .drive(c_out[gi]),
            .drive_oe(c_oe[gi]),
            .pull_up(c_up[gi]),
            .pull_dn(c_dn[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Register reads

   // Disabled pins report the stored bit; only enabled inputs report the pad
   assign level_rd = (is_in & q.in_lat) | (~is_in & q.level); // RQ11

   always_comb begin
      unique case (rd_addr)
         OFS_DRIVE_MODE_A: rd_data = q.mode_a;
         OFS_DRIVE_MODE_B: rd_data = q.mode_b;
         OFS_OUTPUT_SELECT: rd_data = q.out_sel;
         OFS_PORT_ACTIVE: rd_data = q.active;
         OFS_PORT_LEVEL, OFS_LEVEL_RAISE, OFS_LEVEL_LOWER, OFS_LEVEL_INVERT: rd_data = level_rd; // RQ14
         default: rd_data = UNMAPPED_READ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      n = q;
      n.soft_restart = 1'b0;
      n.in_lat = pad_in; // RQ12
      // Level seen by the pads only moves between conversions
      if (!conv_busy) n.drive_lvl = q.level; // RQ10
      n.p_out = c_out;
      n.p_oe = c_oe;
      n.p_up = c_up;
      n.p_dn = c_dn;
      if (wr_stb) begin // RQ3
         unique case (wr_addr)
            OFS_DRIVE_MODE_A: n.mode_a = wr_data;
            OFS_DRIVE_MODE_B: n.mode_b = wr_data;
            OFS_PORT_LEVEL: n.level = wr_data; // RQ9
            OFS_OUTPUT_SELECT: n.out_sel = wr_data;
            OFS_PORT_ACTIVE: n.active = wr_data;
            OFS_LEVEL_RAISE: n.level = q.level | wr_data; // RQ13
            OFS_LEVEL_LOWER: n.level = q.level & ~wr_data; // RQ13
            OFS_LEVEL_INVERT: n.level = q.level ^ wr_data; // RQ13
            default: ;
         endcase
         if (wr_addr == OFS_SOFT_RESTART && wr_data == SOFT_RESTART_KEY) begin
            n = '0; // RQ1 RQ19
            n.in_lat = pad_in;
            n.soft_restart = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q <= '0; // RQ5 RQ19
      end else begin
         q <= n;
      end
   end

   assign pad_out = q.p_out;
   assign pad_oe = q.p_oe;
   assign pull_up_en = q.p_up;
   assign pull_dn_en = q.p_dn;
   assign soft_restart_pulse = q.soft_restart;

endmodule // touch_ctrl_gpio_port
`default_nettype wire
